//--- verilog/ptrp_pkg.sv
package ptrp_pkg;

    // ************************************************************
    // fifo organisation
    // ************************************************************
    localparam int unsigned DEPTH_32 = 32;
    localparam int unsigned WIDTH_32 = 36;
    localparam int unsigned DEPTH_64 = 16;
    localparam int unsigned WIDTH_64 = 72;
    localparam int unsigned CNT_W    = 6;
    localparam logic [5:0]  AFULL_FREE = 6'h04;

    // ************************************************************
    // latencies in clock cycles, and the page bit index
    // ************************************************************
    localparam logic [5:0]  INIT_LAT_DEF  = 6'h10;
    localparam logic [5:0]  INIT_LAT_LONG = 6'h20;
    localparam logic [3:0]  SUB_LAT       = 4'h8;
    localparam logic [3:0]  READY_HOLD    = 4'h9;
    localparam int unsigned PAGE_BIT      = 18;

    // ************************************************************
    // carriers and codes
    // ************************************************************
    typedef struct packed {
        logic [3:0]  cmd;
        logic [31:0] addr;
        logic        burst;
    } ptrp_req_t;

    typedef enum logic [1:0] {
        PTRP_TERM_NORMAL,
        PTRP_TERM_RETRY,
        PTRP_TERM_DISC
    } ptrp_term_t;

    typedef enum {
        PTRP_IDLE,
        PTRP_INIT_WAIT,
        PTRP_XFER,
        PTRP_SUB_WAIT,
        PTRP_END
    } ptrp_state_t;

endpackage

//--- verilog/ptrp_target_read.sv
`timescale 1ns/100ps

// Overview of operation
// - request low announces operation; user takes address
// - burst disconnects on empty or region crossing
// - fifo 32x36 or 16x72 by bus mode
// - empty first read: retry or wait-states
// - hold keeps empty until full, then drains
// - almost-full when four or fewer free
// - full when all occupied; flags may toggle
// - empty mid-burst: disconnect or up to eight waits
// - last-cycle output says burst or single
// - end on last, region or page crossing
// - finish with transfer, discard surplus data
// - delayed mode retries when nothing pending
// - nondelayed waits until data or latency limit
// - delayed: store address, retry until same request
// - hold: retry masters, then burst buffered data
// - request deasserts at every transaction end except a delayed-mode retry
// - ready low during clear and after release
module ptrp_target_read #(
    parameter bit         WIDE64   = 1'b0,
    parameter logic [5:0] INIT_LAT = ptrp_pkg::INIT_LAT_DEF
) (
    input  wire logic                ref_clk_in,     // 125 MHz clock
    input  wire logic                rst_n_in,       // sync reset
    input  wire logic                pci_req_vld_in, // master read request
    input  wire ptrp_pkg::ptrp_req_t pci_req_in,     // its command/address
    input  wire logic                pci_rdy_in,     // master takes word
    input  wire logic                pci_last_in,    // master last phase
    input  wire logic                pci_bar_end_in, // region boundary hit
    output logic [71:0]              pci_data_out,   // read data
    output logic                     pci_data_vld_out, // data valid
    output logic                     pci_term_vld_out, // termination pulse
    output ptrp_pkg::ptrp_term_t     pci_term_out,   // termination kind
    output logic                     treq_n_out,     // target request
    output ptrp_pkg::ptrp_req_t      user_req_out,   // command/address
    input  wire logic                addr_en_n_in,   // address enable
    input  wire logic                rd_data_en_n_in, // read data enable
    input  wire logic [71:0]         rd_data_in,     // read data
    output logic                     rd_last_cycle_n_out, // single read
    output logic                     rd_fifo_empty_n, // shown nonempty
    output logic                     rd_fifo_almost_full_n, // almost full
    output logic                     rd_fifo_full_n, // full
    input  wire logic                burst_pend_n_in, // wait when empty
    input  wire logic                delayed_n_in,   // delayed mode
    input  wire logic                rd_hold_in,     // defer nonempty
    input  wire logic                target_side_clear_n, // target clear
    output logic                     target_ready_out // target ready
);

    // ************************************************************
    // sizing
    // ************************************************************
    localparam int unsigned DEPTH = WIDE64 ? ptrp_pkg::DEPTH_64
                                           : ptrp_pkg::DEPTH_32;
    localparam int unsigned WIDTH = WIDE64 ? ptrp_pkg::WIDTH_64
                                           : ptrp_pkg::WIDTH_32;
    localparam logic [5:0]  CAP   = 6'(DEPTH);
    localparam logic [31:0] STEP  = WIDE64 ? 32'h8 : 32'h4;
    localparam int unsigned PAGE_BIT_I = ptrp_pkg::PAGE_BIT;

    ptrp_pkg::ptrp_state_t state_q;
    logic [WIDTH-1:0]      mem_q [DEPTH];
    logic [4:0]            wr_ptr_q;
    logic [4:0]            rd_ptr_q;
    logic [5:0]            cnt_q;
    logic [5:0]            cnt_d;
    logic                  pend_q;
    logic                  taken_q;
    logic                  show_q;
    logic [5:0]            wait_q;
    logic [31:0]           cur_addr_q;
    logic                  stop_q;
    logic [3:0]            rdy_cnt_q;
    logic                  clr_q;
    logic                  flush;
    logic                  wr;
    logic                  rd;
    logic                  live;
    logic                  match;
    logic [1:0]            sk_cnt_q;
    logic [71:0]           sk_tail_q;
    logic                  sk_pop;
    logic                  sk_push;
    logic [71:0]           rd_word;
    logic [31:0]           next_addr;

    // ************************************************************
    // fifo core
    // ************************************************************
    assign live  = !treq_n_out && taken_q;
    assign flush = (state_q == ptrp_pkg::PTRP_END) || clr_q;
    // words beyond full are dropped; the user must watch full
    assign wr    = live && !rd_data_en_n_in && (cnt_q != CAP);
    assign rd    = (state_q == ptrp_pkg::PTRP_XFER
                    || state_q == ptrp_pkg::PTRP_SUB_WAIT)
                   && (cnt_q != 6'h00) && show_q && (sk_cnt_q != 2'h2);
    assign cnt_d = flush ? 6'h00
                 : 6'(cnt_q + {5'h00, wr} - {5'h00, rd});
    assign rd_word = 72'(mem_q[rd_ptr_q]);

    always_ff @(posedge ref_clk_in)
    begin
        if (wr)
        begin
            mem_q[wr_ptr_q] <= rd_data_in[WIDTH-1:0];
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || flush)
        begin
            wr_ptr_q <= 5'h00;
            rd_ptr_q <= 5'h00;
            cnt_q    <= 6'h00;
        end
        else
        begin
            if (wr)
            begin
                wr_ptr_q <= (wr_ptr_q == 5'(DEPTH - 1)) ? 5'h00
                            : 5'(wr_ptr_q + 5'h01);
            end
            if (rd)
            begin
                rd_ptr_q <= (rd_ptr_q == 5'(DEPTH - 1)) ? 5'h00
                            : 5'(rd_ptr_q + 5'h01);
            end
            cnt_q <= cnt_d;
        end
    end

    // ************************************************************
    // flags
    // ************************************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            rd_fifo_full_n        <= 1'b1;
            rd_fifo_almost_full_n <= 1'b1;
        end
        else
        begin
            rd_fifo_full_n        <= (cnt_d != CAP);
            rd_fifo_almost_full_n <= (6'(CAP - cnt_d)
                                      > ptrp_pkg::AFULL_FREE);
        end
    end

    // under hold, nonempty appears only once full, then sticks
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            show_q <= 1'b0;
        end
        else if (cnt_d == 6'h00)
        begin
            show_q <= 1'b0;
        end
        else if (!rd_hold_in || cnt_d == CAP)
        begin
            show_q <= 1'b1;
        end
    end

    assign rd_fifo_empty_n = show_q;

    // ************************************************************
    // two-entry output buffer
    // ************************************************************
    // the master may stall; the buffer keeps the word in flight
    assign sk_pop  = pci_data_vld_out && pci_rdy_in;
    assign sk_push = rd;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || flush)
        begin
            sk_cnt_q         <= 2'h0;
            pci_data_vld_out <= 1'b0;
            pci_data_out     <= 72'h0;
            sk_tail_q        <= 72'h0;
        end
        else
        begin
            unique case ({sk_push, sk_pop})
                2'b10:
                begin
                    if (sk_cnt_q == 2'h0)
                    begin
                        pci_data_out <= rd_word;
                    end
                    else
                    begin
                        sk_tail_q <= rd_word;
                    end
                    sk_cnt_q <= 2'(sk_cnt_q + 2'h1);
                end
                2'b01:
                begin
                    pci_data_out <= sk_tail_q;
                    sk_cnt_q     <= 2'(sk_cnt_q - 2'h1);
                end
                2'b11:
                begin
                    if (sk_cnt_q == 2'h1)
                    begin
                        pci_data_out <= rd_word;
                    end
                    else
                    begin
                        pci_data_out <= sk_tail_q;
                        sk_tail_q    <= rd_word;
                    end
                end
                2'b00:
                begin
                end
            endcase
            pci_data_vld_out <= (sk_cnt_q != 2'h0 || sk_push)
                                && !(sk_cnt_q == 2'h1 && sk_pop
                                     && !sk_push);
        end
    end

    // ************************************************************
    // transaction control
    // ************************************************************
    assign match     = pci_req_in.addr == user_req_out.addr;
    assign next_addr = 32'(cur_addr_q + STEP);

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || clr_q)
        begin
            state_q             <= ptrp_pkg::PTRP_IDLE;
            treq_n_out          <= 1'b1;
            pend_q              <= 1'b0;
            taken_q             <= 1'b0;
            wait_q              <= 6'h00;
            stop_q              <= 1'b0;
            cur_addr_q          <= 32'h0;
            user_req_out        <= '0;
            rd_last_cycle_n_out <= 1'b1;
            pci_term_vld_out    <= 1'b0;
            pci_term_out        <= ptrp_pkg::PTRP_TERM_NORMAL;
        end
        else
        begin
            pci_term_vld_out <= 1'b0;
            if (!treq_n_out && !addr_en_n_in)
            begin
                taken_q <= 1'b1;
            end
            unique case (state_q)
                ptrp_pkg::PTRP_IDLE:
                begin
                    wait_q <= 6'h00;
                    stop_q <= 1'b0;
                    if (pci_req_vld_in && !pend_q)
                    begin
                        user_req_out        <= pci_req_in;
                        cur_addr_q          <= pci_req_in.addr;
                        treq_n_out          <= 1'b0;
                        taken_q             <= 1'b0;
                        rd_last_cycle_n_out <= pci_req_in.burst;
                        if (!delayed_n_in)
                        begin
                            pend_q           <= 1'b1;
                            pci_term_vld_out <= 1'b1;
                            pci_term_out     <= ptrp_pkg::PTRP_TERM_RETRY;
                        end
                        else
                        begin
                            state_q <= ptrp_pkg::PTRP_INIT_WAIT;
                        end
                    end
                    else if (pci_req_vld_in)
                    begin
                        if (match && show_q)
                        begin
                            state_q <= ptrp_pkg::PTRP_XFER;
                        end
                        else
                        begin
                            pci_term_vld_out <= 1'b1;
                            pci_term_out     <= ptrp_pkg::PTRP_TERM_RETRY;
                        end
                    end
                end
                ptrp_pkg::PTRP_INIT_WAIT:
                begin
                    wait_q <= 6'(wait_q + 6'h01);
                    if (show_q)
                    begin
                        state_q <= ptrp_pkg::PTRP_XFER;
                    end
                    else if (6'(wait_q + 6'h01) >= INIT_LAT)
                    begin
                        pci_term_vld_out <= 1'b1;
                        pci_term_out     <= ptrp_pkg::PTRP_TERM_RETRY;
                        state_q          <= ptrp_pkg::PTRP_END;
                    end
                end
                ptrp_pkg::PTRP_XFER, ptrp_pkg::PTRP_SUB_WAIT:
                begin
                    if (pci_bar_end_in)
                    begin
                        stop_q <= 1'b1;
                    end
                    if (sk_pop)
                    begin
                        cur_addr_q <= next_addr;
                        wait_q     <= 6'h00;
                        state_q    <= ptrp_pkg::PTRP_XFER;
                        if (pci_last_in || !rd_last_cycle_n_out)
                        begin
                            pci_term_vld_out <= 1'b1;
                            pci_term_out     <= ptrp_pkg::PTRP_TERM_NORMAL;
                            state_q          <= ptrp_pkg::PTRP_END;
                        end
                        else if (stop_q || pci_bar_end_in
                                 || next_addr[PAGE_BIT_I]
                                    != cur_addr_q[PAGE_BIT_I])
                        begin
                            pci_term_vld_out <= 1'b1;
                            pci_term_out     <= ptrp_pkg::PTRP_TERM_DISC;
                            state_q          <= ptrp_pkg::PTRP_END;
                        end
                    end
                    else if (!pci_data_vld_out && !show_q && !rd)
                    begin
                        // fifo ran dry in mid burst
                        if (burst_pend_n_in
                            || wait_q[3:0] >= ptrp_pkg::SUB_LAT)
                        begin
                            pci_term_vld_out <= 1'b1;
                            pci_term_out     <= ptrp_pkg::PTRP_TERM_DISC;
                            state_q          <= ptrp_pkg::PTRP_END;
                        end
                        else
                        begin
                            wait_q  <= 6'(wait_q + 6'h01);
                            state_q <= ptrp_pkg::PTRP_SUB_WAIT;
                        end
                    end
                end
                ptrp_pkg::PTRP_END:
                begin
                    // surplus words are flushed with the request drop
                    treq_n_out <= 1'b1;
                    pend_q     <= 1'b0;
                    taken_q    <= 1'b0;
                    state_q    <= ptrp_pkg::PTRP_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // target clear and ready
    // ************************************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            clr_q            <= 1'b0;
            rdy_cnt_q        <= 4'h0;
            target_ready_out <= 1'b0;
        end
        else
        begin
            clr_q <= !target_side_clear_n;
            if (!target_side_clear_n || clr_q)
            begin
                rdy_cnt_q        <= 4'h0;
                target_ready_out <= 1'b0;
            end
            else if (rdy_cnt_q != ptrp_pkg::READY_HOLD)
            begin
                rdy_cnt_q <= 4'(rdy_cnt_q + 4'h1);
            end
            else
            begin
                target_ready_out <= 1'b1;
            end
        end
    end

endmodule

//--- testbench/ptrp_target_read_chk.sv
`timescale 1ns/100ps
module ptrp_target_read_chk #(
    parameter logic [5:0] INIT_LAT = ptrp_pkg::INIT_LAT_DEF
) (
    input wire logic                 ref_clk_in,            // clock
    input wire logic                 rst_n_in,              // reset
    input wire logic                 pci_req_vld_in,        // request
    input wire ptrp_pkg::ptrp_req_t  pci_req_in,            // request info
    input wire logic                 pci_rdy_in,            // master takes
    input wire logic [71:0]          pci_data_out,          // read word
    input wire logic                 pci_data_vld_out,      // word valid
    input wire logic                 pci_term_vld_out,      // term pulse
    input wire ptrp_pkg::ptrp_term_t pci_term_out,          // term kind
    input wire logic                 treq_n_out,            // target request
    input wire logic                 rd_last_cycle_n_out,   // single read
    input wire logic                 rd_fifo_empty_n,       // nonempty
    input wire logic                 rd_fifo_almost_full_n, // almost full
    input wire logic                 rd_fifo_full_n,        // full
    input wire logic                 delayed_n_in,          // delayed mode
    input wire logic                 rd_hold_in,            // hold
    input wire logic                 target_side_clear_n,   // clear
    input wire logic                 target_ready_out       // ready
);
    // ************************************************************
    // port relations
    // ************************************************************
    localparam logic [5:0] LIM = INIT_LAT + 6'h03;
    logic [5:0] wait_q;
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // initial and mid-burst waits share one bound
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || !delayed_n_in || treq_n_out || pci_data_vld_out
            || pci_term_vld_out)
            wait_q <= 6'h00;
        else
            wait_q <= wait_q + 6'h01;
    end
    reset_vals_a: assert property (disable iff (1'b0)
        !rst_n_in |=> treq_n_out && rd_fifo_full_n && rd_fifo_almost_full_n
        && !rd_fifo_empty_n && !target_ready_out)
        else $error("outputs wrong after reset");
    full_afull_a: assert property (
        !rd_fifo_full_n |-> !rd_fifo_almost_full_n)
        else $error("full without almost full");
    hold_full_a: assert property (
        rd_hold_in && $rose(rd_fifo_empty_n) |-> !rd_fifo_full_n)
        else $error("nonempty shown under hold before full");
    delay_retry_a: assert property (
        pci_req_vld_in && !delayed_n_in && treq_n_out |=> pci_term_vld_out
        && pci_term_out == ptrp_pkg::PTRP_TERM_RETRY && !treq_n_out)
        else $error("no retry with request in delayed mode");
    end_treq_a: assert property (
        pci_term_vld_out && (delayed_n_in
        || pci_term_out != ptrp_pkg::PTRP_TERM_RETRY) |-> ##[1:2] treq_n_out)
        else $error("request kept after end");
    wait_bound_a: assert property (
        wait_q <= LIM)
        else $error("too many wait cycles");
    last_kind_a: assert property (
        !treq_n_out && !$fell(treq_n_out)
        |-> rd_last_cycle_n_out == pci_req_in.burst)
        else $error("last cycle does not match burst");
    data_hold_a: assert property (
        pci_data_vld_out && !pci_rdy_in && target_side_clear_n
        && !pci_term_vld_out |=> pci_data_vld_out && $stable(pci_data_out))
        else $error("untaken word dropped or changed");
    clear_low_a: assert property (
        !target_side_clear_n |=> !target_ready_out)
        else $error("ready high during clear");
    ready_seq_a: assert property (
        $rose(target_side_clear_n)
        |-> !target_ready_out [*8] ##[1:4] target_ready_out)
        else $error("ready timing after clear wrong");
endmodule
bind ptrp_target_read ptrp_target_read_chk #(.INIT_LAT(INIT_LAT)) i_chk (
    .ref_clk_in, .rst_n_in, .pci_req_vld_in, .pci_req_in, .pci_rdy_in,
    .pci_data_out, .pci_data_vld_out, .pci_term_vld_out, .pci_term_out,
    .treq_n_out, .rd_last_cycle_n_out, .rd_fifo_empty_n,
    .rd_fifo_almost_full_n, .rd_fifo_full_n, .delayed_n_in, .rd_hold_in,
    .target_side_clear_n, .target_ready_out);

//--- testbench/ptrp_user_model.sv
`timescale 1ns/100ps
module ptrp_user_model (
    input  wire logic        clk_in,        // clock
    input  wire logic        rst_n_in,      // reset
    input  wire logic        treq_n_in,     // target request
    input  wire logic        full_n_in,     // fifo full
    input  wire logic [7:0]  n_words_in,    // words to supply
    input  wire logic [7:0]  delay_in,      // slow start
    output logic             addr_en_n_out, // address enable
    output logic             data_en_n_out, // data enable
    output logic [71:0]      data_out       // read data
);
    logic [1:0] ph_q;
    logic [7:0] wait_q;
    logic [7:0] cnt_q;
    logic       go;
    // gated by full at once, so a refused word is never counted
    assign go = ph_q == 2'h2 && wait_q == 8'h00 && !treq_n_in
                && full_n_in && cnt_q < n_words_in;
    assign data_en_n_out = !go;
    // idle bus shows the inverse of the last word, never a stale copy
    assign data_out = go ? {9{cnt_q}} : ~{9{cnt_q - 8'h01}};
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || treq_n_in)
        begin
            ph_q          <= 2'h0;
            wait_q        <= 8'h00;
            cnt_q         <= 8'h00;
            addr_en_n_out <= 1'b1;
        end
        else if (ph_q == 2'h0)
        begin
            addr_en_n_out <= 1'b0;
            ph_q          <= 2'h1;
        end
        else if (ph_q == 2'h1)
        begin
            addr_en_n_out <= 1'b1;
            wait_q        <= delay_in;
            ph_q          <= 2'h2;
        end
        else if (wait_q != 8'h00)
            wait_q <= wait_q - 8'h01;
        else if (go)
            cnt_q <= cnt_q + 8'h01;
    end
endmodule

//--- testbench/tb.sv
`timescale 1ns/100ps
module tb;
    logic                 clk;
    logic                 rst_n = 1'b0;
    logic                 vld   = 1'b0;
    logic                 rdy   = 1'b0;
    logic                 dl_n  = 1'b1;
    logic                 bp_n  = 1'b1;
    logic                 hold  = 1'b0;
    logic                 clr_n = 1'b1;
    logic [7:0]           nw    = 8'h00;
    logic [7:0]           dly   = 8'h00;
    ptrp_pkg::ptrp_req_t  rq    = '0;
    ptrp_pkg::ptrp_term_t term;
    logic                 dvld, tvld, treq_n, last_n, emp_n, af_n, fl_n;
    logic                 t_rdy, aen_n, den_n;
    logic [71:0]          dat, rdat;
    int                   err_total = 0;
    int                   n_tests   = 0;
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ptrp_target_read i_ptrp_target_read (
        .ref_clk_in(clk), .rst_n_in(rst_n), .pci_req_vld_in(vld),
        .pci_req_in(rq), .pci_rdy_in(rdy), .pci_last_in(1'b0),
        .pci_bar_end_in(1'b0), .pci_data_out(dat), .pci_data_vld_out(dvld),
        .pci_term_vld_out(tvld), .pci_term_out(term), .treq_n_out(treq_n),
        .user_req_out(), .addr_en_n_in(aen_n), .rd_data_en_n_in(den_n),
        .rd_data_in(rdat), .rd_last_cycle_n_out(last_n),
        .rd_fifo_empty_n(emp_n), .rd_fifo_almost_full_n(af_n),
        .rd_fifo_full_n(fl_n), .burst_pend_n_in(bp_n), .delayed_n_in(dl_n),
        .rd_hold_in(hold), .target_side_clear_n(clr_n),
        .target_ready_out(t_rdy));
    ptrp_user_model i_ptrp_user_model (
        .clk_in(clk), .rst_n_in(rst_n), .treq_n_in(treq_n), .full_n_in(fl_n),
        .n_words_in(nw), .delay_in(dly), .addr_en_n_out(aen_n),
        .data_en_n_out(den_n), .data_out(rdat));
    // ************************************************************
    // shared helpers
    // ************************************************************
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [35:0] pat(input int i);
        return {i[3:0], {4{i[7:0]}}};
    endfunction
    task automatic req(input logic [31:0] a, input logic b);
        rq = '{4'h6, a, b};
        vld = 1'b1;
        tick(1);
        vld = 1'b0;
    endtask
    // master takes every other cycle so the fifo runs ahead of it
    task automatic xfer(input int n, input ptrp_pkg::ptrp_term_t t,
                        output int gap);
        int i, k, lk;
        i = 0;
        lk = 0;
        for (k = 0; k < 300 && tvld !== 1'b1; k++)
        begin
            rdy = k[0];
            if (dvld === 1'b1 && rdy)
            begin
                chk(dat[35:0], pat(i));
                i++;
                lk = k;
            end
            tick(1);
        end
        rdy = 1'b0;
        chk(i, n);
        chk({tvld, term}, {1'b1, t});
        gap = k - lk;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic s_reset();
        chk({treq_n, fl_n, af_n, emp_n, t_rdy}, 5'h1c);
        tick(11);
        chk(t_rdy, 1'b1);
        $display("test reset done");
    endtask
    task automatic s_delayed();
        int g;
        dl_n = 1'b0;
        nw = 8'h03;
        req(32'h0000_1000, 1'b0);
        chk({tvld, treq_n, term}, {2'b10, ptrp_pkg::PTRP_TERM_RETRY});
        for (g = 0; g < 40 && emp_n !== 1'b1; g++)
            tick(1);
        chk(last_n, 1'b0);
        req(32'h0000_2000, 1'b0);
        chk({tvld, term}, {1'b1, ptrp_pkg::PTRP_TERM_RETRY});
        tick(1);
        req(32'h0000_1000, 1'b0);
        xfer(1, ptrp_pkg::PTRP_TERM_NORMAL, g);
        tick(2);
        chk({treq_n, emp_n}, 2'b10);
        $display("test delayed done");
    endtask
    task automatic s_burst(input logic bp);
        int g;
        dl_n = 1'b1;
        bp_n = bp;
        nw = 8'h05;
        req(32'h0000_3000, 1'b1);
        xfer(5, ptrp_pkg::PTRP_TERM_DISC, g);
        if (bp)
            chk(g <= 4, 1'b1);
        else
            chk(g >= 9 && g <= 13, 1'b1);
        tick(4);
        $display("test burst done");
    endtask
    task automatic s_timeout();
        int g;
        nw = 8'h01;
        dly = 8'h28;
        req(32'h0000_4000, 1'b1);
        xfer(0, ptrp_pkg::PTRP_TERM_RETRY, g);
        chk(g >= 15 && g <= 20, 1'b1);
        tick(2);
        chk(treq_n, 1'b1);
        dly = 8'h00;
        $display("test timeout done");
    endtask
    task automatic s_hold();
        int g;
        int wr;
        logic seen;
        dl_n = 1'b0;
        hold = 1'b1;
        bp_n = 1'b1;
        nw = 8'h20;
        wr = 0;
        seen = 1'b0;
        req(32'h0000_5000, 1'b1);
        chk(term, ptrp_pkg::PTRP_TERM_RETRY);
        for (g = 0; g < 100 && fl_n !== 1'b0; g++)
        begin
            chk(emp_n, 1'b0);
            if (af_n === 1'b0 && !seen)
            begin
                chk(wr, 28);
                seen = 1'b1;
            end
            if (den_n === 1'b0)
                wr++;
            tick(1);
        end
        chk({emp_n, 8'(wr)}, {1'b1, 8'h20});
        req(32'h0000_5000, 1'b1);
        xfer(32, ptrp_pkg::PTRP_TERM_DISC, g);
        hold = 1'b0;
        tick(4);
        $display("test hold done");
    endtask
    task automatic s_clear();
        int n;
        clr_n = 1'b0;
        tick(3);
        chk(t_rdy, 1'b0);
        clr_n = 1'b1;
        for (n = 0; n < 30 && t_rdy !== 1'b1; n++)
            tick(1);
        chk(n >= 8 && n <= 11, 1'b1);
        $display("test clear done");
    endtask
    initial
    begin
        #40000;
        err_total++;
        conclude();
    end
    initial
    begin
        tick(5);
        rst_n = 1'b1;
        s_reset();
        s_delayed();
        s_burst(1'b1);
        s_burst(1'b0);
        s_timeout();
        s_hold();
        s_clear();
        conclude();
    end
endmodule
